/* File: src/tkdp_pkg.sv */
// tkdp_pkg: constants and types shared by the touch key processing files
// assumes one system clock; burst pacing arrives as strobes from the scanner
package tkdp_pkg;

    localparam logic [7:0] REF_HIGH_LIMIT = 8'hBF;
    localparam logic [7:0] REF_LOW_LIMIT  = 8'h40;
    localparam logic [4:0] RECAL_BURSTS   = 5'h1A;

    localparam logic [7:0] NEG_THR_RST    = 8'h0A;
    localparam logic [7:0] POS_THR_RST    = 8'h0A;
    localparam logic [7:0] DRIFT_UP_RST   = 8'h02;
    localparam logic [7:0] DRIFT_DN_RST   = 8'h08;
    localparam logic [3:0] TARGET_RST     = 4'h2;
    localparam logic [7:0] NEG_DLY_RST    = 8'h00;
    localparam logic [7:0] POS_DLY_RST    = 8'h04;
    localparam logic [7:0] REF_RST        = 8'h80;
    localparam logic       RECAL_ON_RST   = 1'b1;

    typedef enum logic [1:0] {
        HYS_12P5 = 2'h0,
        HYS_25   = 2'h1,
        HYS_50   = 2'h2
    } tkdp_hys_t;

    typedef enum logic [2:0] {
        CFG_NEG_THR  = 3'h0,
        CFG_POS_THR  = 3'h1,
        CFG_DRIFT_UP = 3'h2,
        CFG_DRIFT_DN = 3'h3,
        CFG_TARGET   = 3'h4,
        CFG_NEG_DLY  = 3'h5,
        CFG_POS_DLY  = 3'h6
    } tkdp_cfg_t;

    typedef enum logic {
        MODE_RUN   = 1'b0,
        MODE_RECAL = 1'b1
    } tkdp_mode_t;

endpackage : tkdp_pkg

/* File: src/tkdp_level.sv */
// tkdp_level: threshold and hysteresis comparisons for one key
// assumes reference, signal and threshold amounts of equal width
`timescale 1ns/10ps
module tkdp_level
    import tkdp_pkg::*;
#(
    parameter int DW = 8
) (
    input  wire logic [DW-1:0] refLvl,
    input  wire logic [DW-1:0] sig,
    input  wire logic [DW-1:0] negThr,
    input  wire logic [DW-1:0] posThr,
    input  wire logic [1:0]    negHys,
    input  wire logic [1:0]    posHys,
    output logic               belowNeg,
    output logic               belowNegDrop,
    output logic               abovePos,
    output logic               abovePosDrop
);

    function automatic logic [DW-1:0] hysAmt(input logic [DW-1:0] thr,
                                             input logic [1:0]    sel);
        case (sel)
            HYS_12P5: hysAmt = thr >> 3;
            HYS_25:   hysAmt = thr >> 2;
            HYS_50:   hysAmt = thr >> 1;
            default:  hysAmt = thr >> 3;
        endcase
    endfunction : hysAmt

    logic [DW:0] sigNeg;
    logic [DW:0] sigNegDrop;
    logic [DW:0] refPos;
    logic [DW:0] refPosDrop;

    // levels follow the live reference, so drift moves them too
    assign sigNeg       = {1'b0, sig} + {1'b0, negThr};
    assign sigNegDrop   = sigNeg - {1'b0, hysAmt(negThr, negHys)};
    assign refPos       = {1'b0, refLvl} + {1'b0, posThr};
    assign refPosDrop   = refPos - {1'b0, hysAmt(posThr, posHys)};
    assign belowNeg     = sigNeg < {1'b0, refLvl};
    assign belowNegDrop = sigNegDrop < {1'b0, refLvl};
    assign abovePos     = {1'b0, sig} > refPos;
    assign abovePosDrop = {1'b0, sig} > refPosDrop;

endmodule : tkdp_level

/* File: src/tkdp_drift.sv */
// tkdp_drift: slew limited reference tracking for one key
// assumes a step counter stored per key by the caller
`timescale 1ns/10ps
module tkdp_drift #(
    parameter int DW = 8
) (
    input  wire logic [DW-1:0] refLvl,
    input  wire logic [DW-1:0] sig,
    input  wire logic [DW-1:0] stepCnt,
    input  wire logic [DW-1:0] upRate,
    input  wire logic [DW-1:0] dnRate,
    input  wire logic          hold,
    output logic [DW-1:0]      refNxt,
    output logic [DW-1:0]      stepNxt
);

    logic [DW-1:0] rate;
    logic          goUp;

    always_comb begin
        goUp    = sig > refLvl;
        rate    = goUp ? upRate : dnRate;
        refNxt  = refLvl;
        stepNxt = '0;
        // zero rate leaves the key untracked
        if (!hold && sig != refLvl && rate != '0) begin
            if (stepCnt >= rate - {{(DW-1){1'b0}}, 1'b1}) begin
                // one code per step; ends of window stop tracking
                if (goUp && refLvl != '1) begin
                    refNxt = refLvl + {{(DW-1){1'b0}}, 1'b1};
                end else if (!goUp && refLvl != '0) begin
                    refNxt = refLvl - {{(DW-1){1'b0}}, 1'b1};
                end
            end else begin
                stepNxt = stepCnt + {{(DW-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule : tkdp_drift

/* File: src/tkdp_core.sv */
// tkdp_core: per-key drift, threshold, integrator and recalibration
// assumes each burst delivers one sample per key on sampleValid, paced
// by burstStart; host writes per-key setup through the cfg port
`timescale 1ns/10ps

// Summary of operation
// - Touch sample when reference minus signal exceeds negative threshold.
// - Threshold levels are recomputed from the reference whenever it moves.
// - Negative and positive thresholds are separate per-key setup values.
// - Hysteresis selectable as 12.5, 25 or 50 percent of threshold distance.
// - Drop-out level measured back from threshold toward reference.
// - One global negative and one global positive hysteresis for all keys.
// - Reference moves toward signal in slew-limited steps without detection.
// - Tracking pauses while the signal is past the negative threshold.
// - Separate upward and downward tracking rates.
// - Tracking rate per key; zero rate turns tracking off for that key.
// - Tracking stops at window ends; boundary flags ask host to recalibrate.
// - Detection longer than negative delay copies signal into reference.
// - Negative delay of zero disables that recalibration; held per key.
// - After fast recalibration the key detects normally again.
// - Integrator counts detect samples and confirms at the key target.
// - A non-detect sample before the target clears the integrator.
// - A released key counts down to zero before reporting off.
// - Sixteen targets; target zero disables detection, bursts continue.
// - Signal above positive threshold for positive interval recalibrates.
// - Positive interval per key; zero disables positive recalibration.
// - High flag when reference above 191, low flag when below 64.
// - Full recalibration lasts 26 bursts; fast recalibration one burst.
module tkdp_core
    import tkdp_pkg::*;
#(
    parameter int NK = 64,
    parameter int DW = 8,
    parameter int KW = $clog2(NK)
) (
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          burstStart,
    input  wire logic          sampleValid,
    input  wire logic [KW-1:0] sampleKey,
    input  wire logic [DW-1:0] sampleData,
    input  wire logic          cfgWe,
    input  wire logic [KW-1:0] cfgKey,
    input  wire logic [2:0]    cfgField,
    input  wire logic [DW-1:0] cfgData,
    input  wire logic [1:0]    negHystSel,
    input  wire logic [1:0]    posHystSel,
    input  wire logic          fullRecal,
    output logic [NK-1:0]      keyState_r,
    output logic [NK-1:0]      ref_high_flag_r,
    output logic [NK-1:0]      ref_low_flag_r,
    output logic               recalBusy_r
);

    // per-key running state
    logic [DW-1:0] refMem     [NK];
    logic [3:0]    cntMem     [NK];
    logic [DW-1:0] negTmrMem  [NK];
    logic [DW-1:0] posTmrMem  [NK];
    logic [DW-1:0] stepMem    [NK];
    // per-key setup
    logic [DW-1:0] negThrMem  [NK];
    logic [DW-1:0] posThrMem  [NK];
    logic [DW-1:0] upRateMem  [NK];
    logic [DW-1:0] dnRateMem  [NK];
    logic [3:0]    targetMem  [NK];
    logic [DW-1:0] negDlyMem  [NK];
    logic [DW-1:0] posDlyMem  [NK];

    tkdp_mode_t    mode_r;
    tkdp_mode_t    mode_nxt;
    logic [4:0]    recalCnt_r;
    logic [4:0]    recalCnt_nxt;
    logic          recalBusy_nxt;

    logic [DW-1:0] curRef;
    logic [3:0]    curCnt;
    logic [3:0]    target;
    logic          curAct;
    logic [DW-1:0] curNegTmr;
    logic [DW-1:0] curPosTmr;
    logic          belowNeg;
    logic          belowNegDrop;
    logic          abovePos;
    logic          abovePosDrop;
    logic          detS;
    logic          posCond;
    logic          negRecal;
    logic          posRecal;
    logic [DW-1:0] driftRef;
    logic [DW-1:0] driftStep;
    logic [DW-1:0] ref_nxt;
    logic [3:0]    cnt_nxt;
    logic          act_nxt;
    logic [DW-1:0] negTmr_nxt;
    logic [DW-1:0] posTmr_nxt;
    logic [DW-1:0] step_nxt;

    assign curRef    = refMem[sampleKey];
    assign curCnt    = cntMem[sampleKey];
    assign target    = targetMem[sampleKey];
    assign curAct    = keyState_r[sampleKey];
    assign curNegTmr = negTmrMem[sampleKey];
    assign curPosTmr = posTmrMem[sampleKey];

    // hysteresis selects are global, so every key shares them
    tkdp_level #(.DW(DW)) uLevel (
        .refLvl       (curRef),
        .sig          (sampleData),
        .negThr       (negThrMem[sampleKey]),
        .posThr       (posThrMem[sampleKey]),
        .negHys       (negHystSel),
        .posHys       (posHystSel),
        .belowNeg     (belowNeg),
        .belowNegDrop (belowNegDrop),
        .abovePos     (abovePos),
        .abovePosDrop (abovePosDrop)
    );

    tkdp_drift #(.DW(DW)) uDrift (
        .refLvl  (curRef),
        .sig     (sampleData),
        .stepCnt (stepMem[sampleKey]),
        .upRate  (upRateMem[sampleKey]),
        .dnRate  (dnRateMem[sampleKey]),
        .hold    (curAct || belowNeg),
        .refNxt  (driftRef),
        .stepNxt (driftStep)
    );

    // full recalibration sequencer, counted in bursts
    always_comb begin
        mode_nxt     = mode_r;
        recalCnt_nxt = recalCnt_r;
        case (mode_r)
            MODE_RUN: begin
                if (fullRecal) begin
                    mode_nxt     = MODE_RECAL;
                    recalCnt_nxt = '0;
                end
            end
            MODE_RECAL: begin
                if (burstStart) begin
                    if (recalCnt_r == RECAL_BURSTS - 5'h01) begin
                        mode_nxt     = MODE_RUN;
                        recalCnt_nxt = '0;
                    end else begin
                        recalCnt_nxt = recalCnt_r + 5'h01;
                    end
                end
            end
            default: begin
                mode_nxt     = MODE_RUN;
                recalCnt_nxt = '0;
            end
        endcase
        recalBusy_nxt = (mode_nxt == MODE_RECAL);
    end

    // per-sample processing for the addressed key
    always_comb begin
        // active keys use the drop-out level, idle keys the threshold
        detS       = (curAct ? belowNegDrop : belowNeg) && target != '0;
        posCond    = (curPosTmr != '0) ? abovePosDrop : abovePos;
        negRecal   = 1'b0;
        posRecal   = 1'b0;
        ref_nxt    = driftRef;
        step_nxt   = driftStep;
        cnt_nxt    = curCnt;
        act_nxt    = curAct;
        negTmr_nxt = '0;
        posTmr_nxt = '0;
        if (mode_r == MODE_RECAL) begin
            ref_nxt  = sampleData;
            step_nxt = '0;
            cnt_nxt  = '0;
            act_nxt  = 1'b0;
        end else begin
            if (target == '0) begin
                cnt_nxt = '0;
                act_nxt = 1'b0;
            end else if (!curAct) begin
                if (!detS) begin
                    cnt_nxt = '0;
                end else if (curCnt + 4'h1 >= target) begin
                    cnt_nxt = target;
                    act_nxt = 1'b1;
                end else begin
                    cnt_nxt = curCnt + 4'h1;
                end
            end else if (detS) begin
                cnt_nxt = target;
            end else if (curCnt <= 4'h1) begin
                cnt_nxt = '0;
                act_nxt = 1'b0;
            end else begin
                cnt_nxt = curCnt - 4'h1;
            end
            // zero delay never fires, so recal stays off
            if (curAct && negDlyMem[sampleKey] != '0) begin
                if (curNegTmr >= negDlyMem[sampleKey]) begin
                    negRecal = 1'b1;
                end else begin
                    negTmr_nxt = curNegTmr + {{(DW-1){1'b0}}, 1'b1};
                end
            end
            if (posCond && posDlyMem[sampleKey] != '0) begin
                if (curPosTmr + {{(DW-1){1'b0}}, 1'b1}
                        >= posDlyMem[sampleKey]) begin
                    posRecal = 1'b1;
                end else begin
                    posTmr_nxt = curPosTmr + {{(DW-1){1'b0}}, 1'b1};
                end
            end
            // fast recal copies signal into reference and clears integrator, key state, timers and step
            if (negRecal || posRecal) begin
                ref_nxt    = sampleData;
                step_nxt   = '0;
                cnt_nxt    = '0;
                act_nxt    = 1'b0;
                negTmr_nxt = '0;
                posTmr_nxt = '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // device starts with a full recalibration
            mode_r      <= RECAL_ON_RST ? MODE_RECAL : MODE_RUN;
            recalCnt_r  <= '0;
            recalBusy_r <= RECAL_ON_RST;
        end else begin
            mode_r      <= mode_nxt;
            recalCnt_r  <= recalCnt_nxt;
            recalBusy_r <= recalBusy_nxt;
        end
    end

    // memory writes; host setup and sample update may share a cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            keyState_r      <= '0;
            ref_high_flag_r <= '0;
            ref_low_flag_r  <= '0;
            for (int k = 0; k < NK; k++) begin
                refMem[k]    <= REF_RST;
                cntMem[k]    <= '0;
                negTmrMem[k] <= '0;
                posTmrMem[k] <= '0;
                stepMem[k]   <= '0;
                negThrMem[k] <= NEG_THR_RST;
                posThrMem[k] <= POS_THR_RST;
                upRateMem[k] <= DRIFT_UP_RST;
                dnRateMem[k] <= DRIFT_DN_RST;
                targetMem[k] <= TARGET_RST;
                negDlyMem[k] <= NEG_DLY_RST;
                posDlyMem[k] <= POS_DLY_RST;
            end
        end else begin
            if (sampleValid) begin
                refMem[sampleKey]          <= ref_nxt;
                cntMem[sampleKey]          <= cnt_nxt;
                negTmrMem[sampleKey]       <= negTmr_nxt;
                posTmrMem[sampleKey]       <= posTmr_nxt;
                stepMem[sampleKey]         <= step_nxt;
                keyState_r[sampleKey]      <= act_nxt;
                ref_high_flag_r[sampleKey] <= ref_nxt > REF_HIGH_LIMIT;
                ref_low_flag_r[sampleKey]  <= ref_nxt < REF_LOW_LIMIT;
            end
            if (cfgWe) begin
                case (cfgField)
                    CFG_NEG_THR:  negThrMem[cfgKey] <= cfgData;
                    CFG_POS_THR:  posThrMem[cfgKey] <= cfgData;
                    CFG_DRIFT_UP: upRateMem[cfgKey] <= cfgData;
                    CFG_DRIFT_DN: dnRateMem[cfgKey] <= cfgData;
                    CFG_TARGET:   targetMem[cfgKey] <= cfgData[3:0];
                    CFG_NEG_DLY:  negDlyMem[cfgKey] <= cfgData;
                    CFG_POS_DLY:  posDlyMem[cfgKey] <= cfgData;
                    default:      ;
                endcase
            end
        end
    end

    // checks; only chk_integ_clear excludes cfg writes in the check cycle, the others do not
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_touch_level: assert property (
        sampleValid && !curAct && target != '0 && mode_r == MODE_RUN
        && {1'b0, sampleData} + {1'b0, negThrMem[sampleKey]}
           < {1'b0, curRef} |-> detS)
        else $error("touch sample not seen below threshold");

    chk_integ_clear: assert property (
        sampleValid && !curAct && !detS && !cfgWe
        |=> cntMem[$past(sampleKey)] == '0)
        else $error("integrator not cleared on idle sample");

    chk_integ_confirm: assert property (
        sampleValid && mode_r == MODE_RUN && !curAct && detS
        && curCnt + 4'h1 == target |=> keyState_r[$past(sampleKey)])
        else $error("touch not confirmed at target");

    chk_release_hold: assert property (
        sampleValid && mode_r == MODE_RUN && curAct && !detS
        && curCnt > 4'h1 && !negRecal && !posRecal
        |=> keyState_r[$past(sampleKey)]
            && cntMem[$past(sampleKey)] == $past(curCnt) - 4'h1)
        else $error("key dropped before count reached zero");

    chk_target_off: assert property (
        sampleValid && target == '0 |=> !keyState_r[$past(sampleKey)])
        else $error("disabled key reported on");

    chk_drift_hold: assert property (
        sampleValid && mode_r == MODE_RUN && belowNeg
        && !negRecal && !posRecal
        |=> refMem[$past(sampleKey)] == $past(curRef))
        else $error("reference moved during detection");

    chk_neg_recal: assert property (
        sampleValid && mode_r == MODE_RUN && curAct
        && negDlyMem[sampleKey] != '0
        && curNegTmr >= negDlyMem[sampleKey]
        |=> refMem[$past(sampleKey)] == $past(sampleData)
            && !keyState_r[$past(sampleKey)])
        else $error("long detection did not fast recalibrate");

    chk_pos_off: assert property (
        sampleValid && mode_r == MODE_RUN && posDlyMem[sampleKey] == '0
        && !negRecal |=> refMem[$past(sampleKey)] == $past(driftRef))
        else $error("positive recal fired while disabled");

    chk_flag_high: assert property (
        sampleValid |=> ref_high_flag_r[$past(sampleKey)]
            == (refMem[$past(sampleKey)] > REF_HIGH_LIMIT))
        else $error("high boundary flag wrong");

    chk_recal_len: assert property (
        $fell(recalBusy_r) |-> $past(burstStart)
            && $past(recalCnt_r) == RECAL_BURSTS - 5'h01)
        else $error("full recalibration length wrong");

    cov_touch:   cover property (sampleValid && !curAct && act_nxt);
    cov_neg_rcl: cover property (sampleValid && negRecal);
    cov_pos_rcl: cover property (sampleValid && posRecal);
    cov_release: cover property (sampleValid && curAct && !act_nxt);

endmodule : tkdp_core

/* File: dv/tkdp_host_model.sv */
// tkdp_host_model: host side that writes key setup and orders recalibration
// assumes the core's clock; drives every output on the falling edge
`timescale 1ns/10ps
module tkdp_host_model
    import tkdp_pkg::*;
#(
    parameter int NK = 4,
    parameter int KW = 2
) (
    input  wire logic          clk,
    input  wire logic [NK-1:0] ref_high_flag_r,
    input  wire logic [NK-1:0] ref_low_flag_r,
    output logic               cfgWe,
    output logic [KW-1:0]      cfgKey,
    output logic [2:0]         cfgField,
    output logic [7:0]         cfgData,
    output logic [1:0]         negHystSel,
    output logic [1:0]         posHystSel,
    output logic               fullRecal
);
    initial begin
        cfgWe = 1'b0;
        cfgKey = '0;
        cfgField = 3'h0;
        cfgData = 8'h00;
        negHystSel = 2'h0;
        posHystSel = 2'h0;
        fullRecal = 1'b0;
    end

    // separate per-key amounts, one field per write
    task automatic cfg_write(input logic [KW-1:0] k, input tkdp_cfg_t f,
                             input logic [7:0] d);
        @(negedge clk);
        cfgWe <= 1'b1;
        cfgKey <= k;
        cfgField <= f;
        cfgData <= d;
        @(negedge clk);
        cfgWe <= 1'b0;
    endtask : cfg_write

    // global selections only; no per-key hysteresis exists
    task automatic set_hyst(input logic [1:0] n, input logic [1:0] p);
        @(negedge clk);
        negHystSel <= n;
        posHystSel <= p;
    endtask : set_hyst

    task automatic pulse_recal();
        @(negedge clk);
        fullRecal <= 1'b1;
        @(negedge clk);
        fullRecal <= 1'b0;
    endtask : pulse_recal

    // a pegged reference cannot heal itself, so the host steps in
    task automatic recal_if_flagged();
        if (|ref_high_flag_r || |ref_low_flag_r) begin
            pulse_recal();
        end
    endtask : recal_if_flagged
endmodule : tkdp_host_model

/* File: dv/tkdp_core_tb_top.sv */
// tkdp_core_tb_top: directed bench for the per-key touch processing core
// assumes the host model for setup and a bench-side sample source
`timescale 1ns/10ps
module tkdp_core_tb_top
    import tkdp_pkg::*;
();
    localparam int NK    = 4;
    localparam int KW    = 2;
    localparam int LIMIT = 12000;
    logic          clk;
    logic          sys_rst;
    logic          burstStart;
    logic          sampleValid;
    logic [KW-1:0] sampleKey;
    logic [7:0]    sampleData;
    logic          cfgWe;
    logic [KW-1:0] cfgKey;
    logic [2:0]    cfgField;
    logic [7:0]    cfgData;
    logic [1:0]    negHystSel;
    logic [1:0]    posHystSel;
    logic          fullRecal;
    logic [NK-1:0] keyState;
    logic [NK-1:0] hiFlag;
    logic [NK-1:0] loFlag;
    logic          recalBusy;
    int            miscompares;
    int            checksDone;
    int            cycles;

    tkdp_core #(.NK(NK)) tkdp_core_i (
        .clk(clk), .sys_rst(sys_rst), .burstStart(burstStart),
        .sampleValid(sampleValid), .sampleKey(sampleKey),
        .sampleData(sampleData), .cfgWe(cfgWe), .cfgKey(cfgKey),
        .cfgField(cfgField), .cfgData(cfgData), .negHystSel(negHystSel),
        .posHystSel(posHystSel), .fullRecal(fullRecal),
        .keyState_r(keyState), .ref_high_flag_r(hiFlag),
        .ref_low_flag_r(loFlag), .recalBusy_r(recalBusy)
    );

    tkdp_host_model #(.NK(NK), .KW(KW)) tkdp_host_model_i (
        .clk(clk), .ref_high_flag_r(hiFlag), .ref_low_flag_r(loFlag),
        .cfgWe(cfgWe), .cfgKey(cfgKey), .cfgField(cfgField),
        .cfgData(cfgData), .negHystSel(negHystSel),
        .posHystSel(posHystSel), .fullRecal(fullRecal)
    );

    always #25 clk = ~clk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // hang guard, sized well above the directed run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic flag(input logic got, input logic exp);
        checksDone++;
        if (got !== exp) begin
            $display("MISMATCH at %0t got %0h expected %0h",
                     $time, got, exp);
            miscompares++;
        end
    endtask : flag

    // one sample, result read a cycle later once it has landed
    task automatic sample(input logic [KW-1:0] k, input logic [7:0] d);
        @(negedge clk);
        sampleValid <= 1'b1;
        sampleKey <= k;
        sampleData <= d;
        @(negedge clk);
        sampleValid <= 1'b0;
    endtask : sample

    task automatic rep(input logic [KW-1:0] k, input logic [7:0] d,
                       input int n);
        repeat (n) sample(k, d);
    endtask : rep

    task automatic burst(input logic [7:0] d);
        @(negedge clk);
        burstStart <= 1'b1;
        @(negedge clk);
        burstStart <= 1'b0;
        for (int k = 0; k < NK; k++) begin
            sample(KW'(k), d);
        end
    endtask : burst

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        burstStart = 1'b0;
        sampleValid = 1'b0;
        sampleKey = '0;
        sampleData = 8'h00;
        cycles = 0;
        repeat (12) @(negedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        flag(recalBusy, 1'b1);
        flag(|keyState, 1'b0);
        repeat (25) burst(8'h80);
        flag(recalBusy, 1'b1);
        burst(8'h80);
        flag(recalBusy, 1'b0);
        for (int k = 0; k < NK; k++) begin
            tkdp_host_model_i.cfg_write(KW'(k), CFG_DRIFT_UP, 8'h00);
            tkdp_host_model_i.cfg_write(KW'(k), CFG_DRIFT_DN, 8'h00);
        end
        tkdp_host_model_i.cfg_write(2'h0, CFG_TARGET, 8'h03);
        tkdp_host_model_i.cfg_write(2'h1, CFG_TARGET, 8'h00);
        tkdp_host_model_i.cfg_write(2'h1, CFG_POS_DLY, 8'h00);
        tkdp_host_model_i.cfg_write(2'h2, CFG_TARGET, 8'h01);
        tkdp_host_model_i.cfg_write(2'h2, CFG_NEG_DLY, 8'h02);
        tkdp_host_model_i.cfg_write(2'h3, CFG_TARGET, 8'h01);
        // integrator on key 0, threshold edge first
        sample(2'h0, 8'h76);
        flag(keyState[0], 1'b0);
        rep(2'h0, 8'h75, 2);
        flag(keyState[0], 1'b0);
        sample(2'h0, 8'h80);
        rep(2'h0, 8'h75, 2);
        flag(keyState[0], 1'b0);
        sample(2'h0, 8'h75);
        flag(keyState[0], 1'b1);
        // drop-out level per hysteresis code
        tkdp_host_model_i.set_hyst(2'h2, 2'h0);
        sample(2'h0, 8'h7A);
        flag(keyState[0], 1'b1);
        tkdp_host_model_i.set_hyst(2'h1, 2'h0);
        sample(2'h0, 8'h77);
        flag(keyState[0], 1'b1);
        tkdp_host_model_i.set_hyst(2'h0, 2'h0);
        sample(2'h0, 8'h77);
        flag(keyState[0], 1'b1);
        sample(2'h0, 8'h80);
        flag(keyState[0], 1'b1);
        sample(2'h0, 8'h80);
        flag(keyState[0], 1'b0);
        // positive excursion, interrupted then complete
        rep(2'h0, 8'h90, 3);
        sample(2'h0, 8'h80);
        rep(2'h0, 8'h90, 3);
        rep(2'h0, 8'h85, 3);
        flag(keyState[0], 1'b0);
        rep(2'h0, 8'h90, 4);
        rep(2'h0, 8'h85, 3);
        flag(keyState[0], 1'b1);
        rep(2'h1, 8'h60, 4);
        flag(keyState[1], 1'b0);
        rep(2'h2, 8'h60, 2);
        flag(keyState[2], 1'b1);
        rep(2'h2, 8'h60, 2);
        flag(keyState[2], 1'b0);
        sample(2'h2, 8'h55);
        flag(keyState[2], 1'b1);
        rep(2'h3, 8'h60, 6);
        flag(keyState[3], 1'b1);
        tkdp_host_model_i.cfg_write(2'h3, CFG_POS_DLY, 8'h00);
        rep(2'h3, 8'h90, 6);
        sample(2'h3, 8'h85);
        flag(keyState[3], 1'b0);
        // own amounts on key 3, then positive drop-out at 50 percent
        tkdp_host_model_i.cfg_write(2'h3, CFG_NEG_THR, 8'h20);
        tkdp_host_model_i.cfg_write(2'h3, CFG_POS_THR, 8'h30);
        tkdp_host_model_i.cfg_write(2'h3, CFG_POS_DLY, 8'h02);
        tkdp_host_model_i.set_hyst(2'h0, 2'h2);
        rep(2'h3, 8'hAA, 2);
        sample(2'h3, 8'h6F);
        flag(keyState[3], 1'b0);
        sample(2'h3, 8'hB4);
        sample(2'h3, 8'hA0);
        // field code 7 must leave the target alone
        tkdp_host_model_i.cfg_write(2'h3, tkdp_cfg_t'(3'h7), 8'h00);
        sample(2'h3, 8'h7F);
        flag(keyState[3], 1'b1);
        // drift on key 1 up to the high boundary and down past the low
        tkdp_host_model_i.cfg_write(2'h1, CFG_DRIFT_UP, 8'h01);
        rep(2'h1, 8'hC0, 62);
        flag(hiFlag[1], 1'b0);
        rep(2'h1, 8'hC0, 4);
        flag(hiFlag[1], 1'b1);
        tkdp_host_model_i.cfg_write(2'h1, CFG_DRIFT_DN, 8'h02);
        rep(2'h1, 8'h00, 8);
        flag(hiFlag[1], 1'b1);
        for (int d = 8'hBF; d >= 8'h30; d--) begin
            rep(2'h1, 8'(d), 2);
        end
        flag(loFlag[1], 1'b1);
        flag(hiFlag[1], 1'b0);
        tkdp_host_model_i.recal_if_flagged();
        flag(recalBusy, 1'b1);
        repeat (5) burst(8'h80);
        tkdp_host_model_i.pulse_recal();
        repeat (21) burst(8'h80);
        flag(recalBusy, 1'b0);
        flag(loFlag[1], 1'b0);
        tally_and_finish();
    end
endmodule : tkdp_core_tb_top
